// ===== core/tbs_pkg.sv
// Purpose: shared constants and types for the two-wire bus share ends
// Assumes: one clock; bus clock is clk divided by two
// Notes: all strobes named _n are active low on the pins
// Contract
// - external owner holds request; processor stays off
// - master drives address, strobe and attributes first
// - master drops begin strobe in second cycle
// - capture address and direction at cycle two
// - chip select, byte enables at cycle four fall
// - transfer ack asserted at cycle five rise
// - zero-wait burst keeps ack for beats two-four
// - ack drops with progress; selects drop on fall
// - hold request wired to grant, driven to acknowledge
// - device drops hold request to grant bus
// - pending request with grant drives flag low
// - grant removed mid cycle: finish then release
// - burst counts as one cycle, keep bus
// - granted with pending: assert flag, begin strobe
// - while granted keep flag and drive bus
// - grant gone at cycle end: drop flag
// - granted without request: implicit, drive nothing
// - request during implicit: explicit, start at once
// - finished without grant: drop flag, tri-state all
// - transfer may start cycle after grant
// - never grant while external device still drives
// - never both begin strobe and address strobe
// - select on external hit only if alternate enabled
package tbs_pkg;
    localparam int CS_COUNT = 8;
    localparam int BE_WIDTH = 4;
    localparam int ADDR_WIDTH = 32;
    localparam int BASE_WIDTH = 16;
    localparam int WAIT_WIDTH = 4;

    // transfer size codes
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;

    // beats per transfer on a 32-bit port
    localparam logic [2:0] LINE_BEATS = 3'h4;
    localparam logic [2:0] SINGLE_BEATS = 3'h1;
    // rising edges spent decoding after capture (cycles three and four)
    localparam logic [1:0] DECODE_RISES = 2'h2;

    localparam logic [CS_COUNT-1:0] CS_IDLE = 8'hFF;
    localparam logic [BE_WIDTH-1:0] BE_IDLE = 4'hF;
    localparam logic BUS_CLOCK_RESET = 1'h0;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic readWrite;
        logic [1:0] transferType;
        logic [2:0] transferModifier;
        logic [1:0] transferSize;
        logic cycleBeginStrobe_n;
        logic transferInProgress_n;
    } tbs_ctl_t;

    // level seen on the shared lines when nobody drives them
    localparam tbs_ctl_t CTL_IDLE = '{addr: 32'h0, readWrite: 1'h1, transferType: 2'h0,
        transferModifier: 3'h0, transferSize: 2'h0, cycleBeginStrobe_n: 1'h1,
        transferInProgress_n: 1'h1};

    typedef enum logic [1:0] {ARB_EXTERNAL, ARB_IMPLICIT, ARB_EXPLICIT} tbs_arb_t;
    typedef enum logic [2:0] {ENG_IDLE, ENG_DECODE, ENG_SELECT, ENG_WAIT, ENG_BEAT,
        ENG_RELEASE} tbs_eng_t;
    typedef enum logic [2:0] {EXT_IDLE, EXT_REQ1, EXT_REQ2, EXT_OWN, EXT_ACCESS,
        EXT_DROP} tbs_ext_t;
endpackage

// ===== core/tbs_bus_if.sv
// Purpose: shared bus between processor end and external master end
// Assumes: both ends clocked by the same clk
// Notes: line levels are resolved here from each end's enable
`timescale 1ns/1ps
interface tbs_bus_if;
    logic busClockOut;
    logic busRise;
    logic busFall;
    logic holdRequest;
    logic busDrivenFlag_n;
    logic holdAcknowledge;
    logic busRequestOut_n;
    tbs_pkg::tbs_ctl_t devCtl;
    tbs_pkg::tbs_ctl_t extCtl;
    tbs_pkg::tbs_ctl_t ctl;
    logic devCtlOe;
    logic extCtlOe;
    logic transferAck_n;
    logic transferAckOe;
    logic ackLine;
    logic [tbs_pkg::CS_COUNT-1:0] chipSelectLine_n;
    logic [tbs_pkg::BE_WIDTH-1:0] byteEnableLines_n;

    assign ctl = devCtlOe ? devCtl : (extCtlOe ? extCtl : tbs_pkg::CTL_IDLE);
    assign ackLine = transferAckOe ? transferAck_n : 1'b1;
    // hold request goes straight onto the grant input, flag onto acknowledge
    assign holdAcknowledge = busDrivenFlag_n;

    modport dev (
        output busClockOut, busRise, busFall, busDrivenFlag_n, busRequestOut_n,
        output devCtl, devCtlOe, transferAck_n, transferAckOe,
        output chipSelectLine_n, byteEnableLines_n,
        input holdRequest, ctl, ackLine
    );
    modport ext (
        output holdRequest, extCtl, extCtlOe,
        input busClockOut, busRise, busFall, holdAcknowledge, ctl, ackLine,
        input chipSelectLine_n, byteEnableLines_n
    );
endinterface

// ===== core/tbs_device_end.sv
// Purpose: processor end: two-wire arbitration and slave-side select and ack
// Assumes: grant input is the external hold request, high means not granted
// Notes: own cycles run through the same select and ack engine
`timescale 1ns/1ps
module tbs_device_end (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // shared bus
    tbs_bus_if.dev bus,
    // own access requests
    input wire logic reqValid,
    input wire logic [tbs_pkg::ADDR_WIDTH-1:0] reqAddr,
    input wire logic reqRead,
    input wire logic [1:0] reqSize,
    input wire logic [1:0] reqType,
    input wire logic [2:0] reqMod,
    output logic reqTaken,
    output logic reqDone,
    // chip select settings
    input wire logic [tbs_pkg::BASE_WIDTH-1:0] csBase [tbs_pkg::CS_COUNT],
    input wire logic [tbs_pkg::CS_COUNT-1:0] alternateMasterEnable,
    input wire logic [tbs_pkg::CS_COUNT-1:0] csAutoAck,
    input wire logic [tbs_pkg::WAIT_WIDTH-1:0] csWait [tbs_pkg::CS_COUNT],
    // status
    output logic isExplicit,
    output logic isImplicit
);
    // ------------------------------------------------------------
    // bus clock divider
    // ------------------------------------------------------------
    logic busClock_q;
    logic riseEn;
    logic fallEn;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busClock_q <= tbs_pkg::BUS_CLOCK_RESET;
        else
            busClock_q <= ~busClock_q;
    end

    assign riseEn = ~busClock_q;
    assign fallEn = busClock_q;
    assign bus.busClockOut = busClock_q;
    assign bus.busRise = riseEn;
    assign bus.busFall = fallEn;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    tbs_pkg::tbs_arb_t arb_q;
    tbs_pkg::tbs_eng_t eng_q;
    tbs_pkg::tbs_ctl_t ownCtl_q;
    logic ownActive_q;
    logic granted;
    logic pending;
    logic engFree;
    logic startOwn;
    logic lastRise;
    logic [2:0] beatCnt_q;
    logic [2:0] beatTotal_q;
    logic busRequest_q;

    assign granted = ~bus.holdRequest;
    assign pending = reqValid & ~ownActive_q;
    assign engFree = (eng_q == tbs_pkg::ENG_IDLE) || (eng_q == tbs_pkg::ENG_RELEASE);
    // a new own cycle never starts in the edge an earlier one ends
    assign startOwn = riseEn & granted & pending & engFree;
    assign lastRise = riseEn && (eng_q == tbs_pkg::ENG_BEAT) && (beatCnt_q == beatTotal_q);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            arb_q <= tbs_pkg::ARB_EXTERNAL;
        else if (riseEn)
        begin
            unique case (arb_q)
                tbs_pkg::ARB_EXTERNAL:
                begin
                    if (granted)
                        arb_q <= pending ? tbs_pkg::ARB_EXPLICIT : tbs_pkg::ARB_IMPLICIT;
                end
                tbs_pkg::ARB_IMPLICIT:
                begin
                    if (!granted)
                        arb_q <= tbs_pkg::ARB_EXTERNAL;
                    else if (pending)
                        arb_q <= tbs_pkg::ARB_EXPLICIT;
                end
                tbs_pkg::ARB_EXPLICIT:
                begin
                    // a burst is one cycle: release is only weighed at its last edge
                    if (ownActive_q)
                    begin
                        if (lastRise && !granted)
                            arb_q <= tbs_pkg::ARB_EXTERNAL;
                    end
                    else if (!granted)
                        arb_q <= tbs_pkg::ARB_EXTERNAL;
                end
            endcase
        end
    end

    assign bus.busDrivenFlag_n = (arb_q != tbs_pkg::ARB_EXPLICIT);
    assign bus.devCtlOe = (arb_q == tbs_pkg::ARB_EXPLICIT);
    assign bus.devCtl = ownCtl_q;
    assign isExplicit = (arb_q == tbs_pkg::ARB_EXPLICIT);
    assign isImplicit = (arb_q == tbs_pkg::ARB_IMPLICIT);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busRequest_q <= 1'b0;
        else if (riseEn)
            busRequest_q <= pending & ~startOwn;
    end

    assign bus.busRequestOut_n = ~busRequest_q;

    // ------------------------------------------------------------
    // own cycle driver
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ownActive_q <= 1'b0;
            ownCtl_q <= tbs_pkg::CTL_IDLE;
            reqTaken <= 1'b0;
            reqDone <= 1'b0;
        end
        else
        begin
            reqTaken <= startOwn;
            reqDone <= lastRise & ownActive_q;
            if (startOwn)
            begin
                ownActive_q <= 1'b1;
                ownCtl_q.addr <= reqAddr;
                ownCtl_q.readWrite <= reqRead;
                ownCtl_q.transferType <= reqType;
                ownCtl_q.transferModifier <= reqMod;
                ownCtl_q.transferSize <= reqSize;
                ownCtl_q.cycleBeginStrobe_n <= 1'b0;
                ownCtl_q.transferInProgress_n <= 1'b0;
            end
            else if (riseEn)
            begin
                ownCtl_q.cycleBeginStrobe_n <= 1'b1;
                if (lastRise && ownActive_q)
                begin
                    ownActive_q <= 1'b0;
                    ownCtl_q.transferInProgress_n <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [tbs_pkg::ADDR_WIDTH-1:0] latAddr_q;
    logic latRead_q;
    logic [1:0] latSize_q;
    logic latExt_q;
    logic [1:0] decCnt_q;
    logic decHit;
    logic [2:0] decIdx;
    logic [2:0] hitIdx_q;

    always_comb
    begin
        decHit = 1'b0;
        decIdx = 3'h0;
        for (int i = tbs_pkg::CS_COUNT - 1; i >= 0; i--)
        begin
            // external hits need the alternate-master enable of that select
            if (latAddr_q[31:16] == csBase[i] && (!latExt_q || alternateMasterEnable[i]))
            begin
                decHit = 1'b1;
                decIdx = 3'(i);
            end
        end
    end

    function automatic logic [3:0] tbsByteEnables(input logic [1:0] size,
        input logic [1:0] low);
        logic [3:0] lanes;
        lanes = 4'hF;
        if (size == tbs_pkg::SIZE_BYTE)
            lanes = 4'h8 >> low;
        else if (size == tbs_pkg::SIZE_WORD)
            lanes = low[1] ? 4'h3 : 4'hC;
        return ~lanes;
    endfunction

    // ------------------------------------------------------------
    // select and acknowledge engine
    // ------------------------------------------------------------
    logic [tbs_pkg::WAIT_WIDTH-1:0] waitCnt_q;
    logic [tbs_pkg::CS_COUNT-1:0] csOut_q;
    logic [tbs_pkg::BE_WIDTH-1:0] beOut_q;
    logic ackOut_q;
    logic ackOe_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eng_q <= tbs_pkg::ENG_IDLE;
            latAddr_q <= '0;
            latRead_q <= 1'b1;
            latSize_q <= tbs_pkg::SIZE_LONG;
            latExt_q <= 1'b0;
            decCnt_q <= 2'h0;
            hitIdx_q <= 3'h0;
            waitCnt_q <= '0;
            beatCnt_q <= 3'h0;
            beatTotal_q <= tbs_pkg::SINGLE_BEATS;
            csOut_q <= tbs_pkg::CS_IDLE;
            beOut_q <= tbs_pkg::BE_IDLE;
            ackOut_q <= 1'b1;
            ackOe_q <= 1'b0;
        end
        else
        begin
            unique case (eng_q)
                tbs_pkg::ENG_IDLE:
                begin
                    // only sampled once; later edges of the burst ignore the lines
                    if (riseEn && !bus.ctl.cycleBeginStrobe_n)
                    begin
                        latAddr_q <= bus.ctl.addr;
                        latRead_q <= bus.ctl.readWrite;
                        latSize_q <= bus.ctl.transferSize;
                        latExt_q <= (arb_q != tbs_pkg::ARB_EXPLICIT);
                        decCnt_q <= 2'h1;
                        eng_q <= tbs_pkg::ENG_DECODE;
                    end
                end
                tbs_pkg::ENG_DECODE:
                begin
                    if (riseEn)
                    begin
                        if (decCnt_q == tbs_pkg::DECODE_RISES)
                        begin
                            hitIdx_q <= decIdx;
                            // a miss is left for other logic to answer
                            eng_q <= decHit ? tbs_pkg::ENG_SELECT : tbs_pkg::ENG_IDLE;
                        end
                        else
                            decCnt_q <= decCnt_q + 2'h1;
                    end
                end
                tbs_pkg::ENG_SELECT:
                begin
                    if (fallEn)
                    begin
                        csOut_q <= ~(8'h01 << hitIdx_q);
                        beOut_q <= tbsByteEnables(latSize_q, latAddr_q[1:0]);
                        waitCnt_q <= csWait[hitIdx_q];
                        ackOe_q <= csAutoAck[hitIdx_q];
                        beatCnt_q <= 3'h0;
                        beatTotal_q <= (latSize_q == tbs_pkg::SIZE_LINE) ?
                            tbs_pkg::LINE_BEATS : tbs_pkg::SINGLE_BEATS;
                        eng_q <= tbs_pkg::ENG_WAIT;
                    end
                end
                tbs_pkg::ENG_WAIT:
                begin
                    if (riseEn)
                    begin
                        if (waitCnt_q == '0)
                        begin
                            ackOut_q <= 1'b0;
                            beatCnt_q <= beatCnt_q + 3'h1;
                            eng_q <= tbs_pkg::ENG_BEAT;
                        end
                        else
                            waitCnt_q <= waitCnt_q - 1'b1;
                    end
                end
                tbs_pkg::ENG_BEAT:
                begin
                    if (riseEn)
                    begin
                        if (beatCnt_q == beatTotal_q)
                        begin
                            ackOut_q <= 1'b1;
                            eng_q <= tbs_pkg::ENG_RELEASE;
                        end
                        else if (csWait[hitIdx_q] == '0)
                            beatCnt_q <= beatCnt_q + 3'h1;
                        else
                        begin
                            ackOut_q <= 1'b1;
                            waitCnt_q <= csWait[hitIdx_q] - 1'b1;
                            eng_q <= tbs_pkg::ENG_WAIT;
                        end
                    end
                end
                tbs_pkg::ENG_RELEASE:
                begin
                    if (fallEn)
                    begin
                        csOut_q <= tbs_pkg::CS_IDLE;
                        beOut_q <= tbs_pkg::BE_IDLE;
                        ackOe_q <= 1'b0;
                        eng_q <= tbs_pkg::ENG_IDLE;
                    end
                end
            endcase
        end
    end

    assign bus.chipSelectLine_n = csOut_q;
    assign bus.byteEnableLines_n = beOut_q;
    assign bus.transferAck_n = ackOut_q;
    assign bus.transferAckOe = ackOe_q;
endmodule

// ===== core/tbs_ext_end.sv
// Purpose: external master end: hold request handshake and own accesses
// Assumes: bus edges come from the processor end's divider
// Notes: counts acknowledge beats on the resolved ack line
`timescale 1ns/1ps
module tbs_ext_end (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // shared bus
    tbs_bus_if.ext bus,
    // user side
    input wire logic wantBus,
    input wire logic cmdValid,
    input wire logic [tbs_pkg::ADDR_WIDTH-1:0] cmdAddr,
    input wire logic cmdRead,
    input wire logic [1:0] cmdSize,
    input wire logic [1:0] cmdType,
    input wire logic [2:0] cmdMod,
    output logic cmdTaken,
    output logic cmdDone,
    output logic ownsBus
);
    // ------------------------------------------------------------
    // hold handshake and access sequencer
    // ------------------------------------------------------------
    tbs_pkg::tbs_ext_t st_q;
    tbs_pkg::tbs_ctl_t ctl_q;
    logic hold_request_q;
    logic drive_q;
    logic [2:0] beats_q;
    logic [2:0] beatTotal_q;
    logic rise;

    assign rise = bus.busRise;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= tbs_pkg::EXT_IDLE;
            ctl_q <= tbs_pkg::CTL_IDLE;
            hold_request_q <= 1'b0;
            drive_q <= 1'b0;
            beats_q <= 3'h0;
            beatTotal_q <= tbs_pkg::SINGLE_BEATS;
            cmdTaken <= 1'b0;
            cmdDone <= 1'b0;
        end
        else
        begin
            cmdTaken <= 1'b0;
            cmdDone <= 1'b0;
            if (rise)
            begin
                unique case (st_q)
                    tbs_pkg::EXT_IDLE:
                    begin
                        if (wantBus || cmdValid)
                        begin
                            hold_request_q <= 1'b1;
                            st_q <= tbs_pkg::EXT_REQ1;
                        end
                    end
                    // one edge for the processor to see the request
                    tbs_pkg::EXT_REQ1:
                        st_q <= tbs_pkg::EXT_REQ2;
                    tbs_pkg::EXT_REQ2:
                    begin
                        if (bus.holdAcknowledge)
                        begin
                            drive_q <= 1'b1;
                            st_q <= tbs_pkg::EXT_OWN;
                        end
                    end
                    tbs_pkg::EXT_OWN:
                    begin
                        if (cmdValid)
                        begin
                            ctl_q.addr <= cmdAddr;
                            ctl_q.readWrite <= cmdRead;
                            ctl_q.transferType <= cmdType;
                            ctl_q.transferModifier <= cmdMod;
                            ctl_q.transferSize <= cmdSize;
                            ctl_q.cycleBeginStrobe_n <= 1'b0;
                            ctl_q.transferInProgress_n <= 1'b0;
                            beats_q <= 3'h0;
                            beatTotal_q <= (cmdSize == tbs_pkg::SIZE_LINE) ?
                                tbs_pkg::LINE_BEATS : tbs_pkg::SINGLE_BEATS;
                            cmdTaken <= 1'b1;
                            st_q <= tbs_pkg::EXT_ACCESS;
                        end
                        else if (!wantBus)
                        begin
                            drive_q <= 1'b0;
                            st_q <= tbs_pkg::EXT_DROP;
                        end
                    end
                    tbs_pkg::EXT_ACCESS:
                    begin
                        ctl_q.cycleBeginStrobe_n <= 1'b1;
                        if (!bus.ackLine)
                        begin
                            beats_q <= beats_q + 3'h1;
                            if (beats_q + 3'h1 == beatTotal_q)
                            begin
                                ctl_q.transferInProgress_n <= 1'b1;
                                cmdDone <= 1'b1;
                                st_q <= tbs_pkg::EXT_OWN;
                            end
                        end
                    end
                    tbs_pkg::EXT_DROP:
                    begin
                        // lines already released one edge earlier
                        hold_request_q <= 1'b0;
                        st_q <= tbs_pkg::EXT_IDLE;
                    end
                endcase
            end
        end
    end

    // only one of begin strobe and address strobe: this end has no address strobe
    assign bus.extCtl = ctl_q;
    assign bus.extCtlOe = drive_q;
    assign bus.holdRequest = hold_request_q;
    assign ownsBus = drive_q;
endmodule

// ===== sim/tbs_bus_chk.sv
// Purpose: timing checks on the shared bus lines
// Assumes: every select has zero waits and auto ack
// Notes: one clock domain, times counted in clk edges
`timescale 1ns/1ps
module tbs_bus_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus lines
    input wire logic busRise,
    input wire logic holdRequest,
    input wire logic busDrivenFlag_n,
    input wire tbs_pkg::tbs_ctl_t ctl,
    input wire logic devCtlOe,
    input wire logic extCtlOe,
    input wire logic ackLine,
    input wire logic [tbs_pkg::CS_COUNT-1:0] chipSelectLine_n,
    input wire logic [tbs_pkg::BE_WIDTH-1:0] byteEnableLines_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_EXT_HOLDS: assert property (extCtlOe |-> holdRequest && busDrivenFlag_n)
        else $error("external drives without hold");
    AST_FLAG_DRIVES: assert property (devCtlOe != busDrivenFlag_n && !(devCtlOe && extCtlOe))
        else $error("drive enable disagrees with flag");
    AST_FLAG_START: assert property ($fell(busDrivenFlag_n) |->
        !$past(holdRequest) && !ctl.cycleBeginStrobe_n)
        else $error("flag taken without grant or strobe");
    AST_FLAG_RELEASE: assert property ($rose(busDrivenFlag_n) |-> $past(holdRequest))
        else $error("flag dropped while granted");
    AST_HOLD_IN_CYCLE: assert property (!busDrivenFlag_n && !ctl.transferInProgress_n && ackLine
        |=> !busDrivenFlag_n)
        else $error("bus let go before last beat");
    AST_SELECT_TIME: assert property (busRise && !ctl.cycleBeginStrobe_n |->
        ##5 chipSelectLine_n == tbs_pkg::CS_IDLE ##1 chipSelectLine_n != tbs_pkg::CS_IDLE)
        else $error("select not at fourth cycle");
    AST_ACK_AFTER_SELECT: assert property ($fell(&chipSelectLine_n) |=> !ackLine)
        else $error("ack late after select");
    AST_LINE_BEATS: assert property ($fell(ackLine) && ctl.transferSize == tbs_pkg::SIZE_LINE
        |-> !ackLine [*8] ##1 ackLine)
        else $error("line ack not four bus cycles");
    AST_ACK_END: assert property ($rose(ackLine) |-> ctl.transferInProgress_n &&
        chipSelectLine_n != tbs_pkg::CS_IDLE ##1 chipSelectLine_n == tbs_pkg::CS_IDLE &&
        byteEnableLines_n == tbs_pkg::BE_IDLE)
        else $error("end of cycle order wrong");
endmodule

// ===== sim/tbs_tb_top.sv
// Purpose: random accesses from both ends, select and lanes checked
// Assumes: chip select i sits at 16'h1000 + i, zero waits
// Notes: grab raises the hold request in mid own cycle
`timescale 1ns/1ps
module tbs_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reqValid = 1'b0, wantBus = 1'b0, cmdValid = 1'b0, rd = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [1:0] size = 2'h0, ttype = 2'h0;
    logic [2:0] tmod = 3'h0;
    logic reqTaken, reqDone, cmdTaken, cmdDone, isExplicit, isImplicit, ownsBus;
    logic [15:0] csBase [tbs_pkg::CS_COUNT];
    logic [3:0] csWait [tbs_pkg::CS_COUNT] = '{default: 4'h0};
    logic [11:0] expQ [$];
    logic [7:0] csPrev = 8'hFF;
    int nFail = 0;
    int checksDone = 0;
    tbs_bus_if tbs_bus_if_inst ();
    wire [11:0] selNow = {tbs_bus_if_inst.chipSelectLine_n, tbs_bus_if_inst.byteEnableLines_n};
    always #10 clk = ~clk;
    initial for (int i = 0; i < 8; i++) csBase[i] = 16'h1000 + 16'(i);
    tbs_device_end tbs_device_end_inst (.clk(clk), .reset_n(reset_n), .bus(tbs_bus_if_inst.dev),
        .reqValid(reqValid), .reqAddr(addr), .reqRead(rd), .reqSize(size), .reqType(ttype),
        .reqMod(tmod), .reqTaken(reqTaken), .reqDone(reqDone), .csBase(csBase),
        .alternateMasterEnable(8'hFF), .csAutoAck(8'hFF), .csWait(csWait),
        .isExplicit(isExplicit), .isImplicit(isImplicit));
    tbs_ext_end tbs_ext_end_inst (.clk(clk), .reset_n(reset_n), .bus(tbs_bus_if_inst.ext),
        .wantBus(wantBus), .cmdValid(cmdValid), .cmdAddr(addr), .cmdRead(rd), .cmdSize(size),
        .cmdType(ttype), .cmdMod(tmod), .cmdTaken(cmdTaken), .cmdDone(cmdDone),
        .ownsBus(ownsBus));
    tbs_bus_chk tbs_bus_chk_inst (.clk(clk), .reset_n(reset_n),
        .busRise(tbs_bus_if_inst.busRise), .holdRequest(tbs_bus_if_inst.holdRequest),
        .busDrivenFlag_n(tbs_bus_if_inst.busDrivenFlag_n), .ctl(tbs_bus_if_inst.ctl),
        .devCtlOe(tbs_bus_if_inst.devCtlOe), .extCtlOe(tbs_bus_if_inst.extCtlOe),
        .ackLine(tbs_bus_if_inst.ackLine), .chipSelectLine_n(tbs_bus_if_inst.chipSelectLine_n),
        .byteEnableLines_n(tbs_bus_if_inst.byteEnableLines_n));
    task automatic check(input logic [11:0] seen, input logic [11:0] want, input string what);
        checksDone++;
        if (seen !== want)
        begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stopTest();
        if (nFail == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [3:0] beN(input logic [1:0] s, input logic [1:0] a);
        case (s)
            tbs_pkg::SIZE_BYTE: return ~(4'h8 >> a);
            tbs_pkg::SIZE_WORD: return a[1] ? 4'hC : 4'h3;
            default: return 4'h0;
        endcase
    endfunction
    // bounded wait for a done or taken pulse, k picks which
    task automatic waitFor(input int k);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while ((k == 0 ? reqTaken : k == 1 ? reqDone : k == 2 ? cmdTaken : cmdDone) !== 1'b1
            && n < 500);
        if (n >= 500)
            nFail++;
    endtask
    task automatic doOp(input bit ext, input bit grab);
        addr = {16'h1000 + 16'($urandom_range(7)), 16'($urandom)};
        size = 2'($urandom);
        ttype = 2'($urandom);
        tmod = 3'($urandom);
        rd = 1'($urandom);
        expQ.push_back({~(8'h01 << addr[18:16]), beN(size, addr[1:0])});
        wantBus = ext;
        cmdValid = ext;
        reqValid = !ext;
        waitFor(ext ? 2 : 0);
        if (!ext)
            check({isExplicit, tbs_bus_if_inst.busRequestOut_n}, 12'h3, "explicit");
        else
            check(12'(ownsBus), 12'h1, "owns");
        cmdValid = 1'b0;
        reqValid = 1'b0;
        wantBus = ext | grab;
        waitFor(ext ? 3 : 1);
        wantBus = 1'b0;
    endtask
    // negedge sampling keeps clear of the register updates
    always @(negedge clk)
    begin
        if (csPrev === 8'hFF && selNow[11:4] !== 8'hFF)
            check(selNow, expQ.size() > 0 ? expQ.pop_front() : 12'hFFF, "select");
        csPrev = selNow[11:4];
    end
    initial
    begin
        void'($urandom(31445));
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({isImplicit, tbs_bus_if_inst.busDrivenFlag_n}, 12'h3, "implicit");
        for (int i = 0; i < 30; i++)
            doOp(1'($urandom), 1'($urandom));
        repeat (20) @(posedge clk);
        check(12'(expQ.size()), 12'h0, "pending");
        stopTest();
    end
    initial
    begin
        #400000;
        nFail++;
        stopTest();
    end
endmodule
